// *** core/rcs_pkg.sv ***
`default_nettype none
package rcs_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [7:0] REG_OVR_ENABLE = 8'h00;
  localparam logic [7:0] REG_OVR_VALUE = 8'h04;
  localparam logic [7:0] REG_SWITCH = 8'h08;
  localparam logic [7:0] REG_APPLIED = 8'h0c;
  localparam logic [7:0] REG_MODE = 8'h10;

  // Field positions inside the 8-bit configuration word
  localparam int FLD_ETH4 = 0;
  localparam int FLD_DBG_ECC = 1;
  localparam int FLD_EEPROM = 2;
  localparam int FLD_MEMDBG_LO = 3;
  localparam int FLD_MEMDBG_HI = 4;
  localparam int FLD_HOSTAGT_LO = 5;
  localparam int FLD_HOSTAGT_HI = 7;

  // Reset values
  localparam logic [7:0] RST_OVR_ENABLE = 8'h00;
  localparam logic [7:0] RST_OVR_VALUE = 8'hfb;

  // Field encodings
  localparam logic ETH4_SERIAL = 1'h0;
  localparam logic [1:0] ETH4_SERIAL_LANE = 2'h3;
  localparam logic DBG_ECC_ON = 1'h0;
  localparam logic [1:0] MEMDBG_LOCAL_BUS = 2'h0;
  localparam logic [1:0] MEMDBG_RESERVED = 2'h1;
  localparam logic [1:0] MEMDBG_MEM_CTRL1 = 2'h2;
  localparam logic [1:0] MEMDBG_MEM_CTRL2 = 2'h3;
  localparam logic [6:0] EEPROM_ADDR_LOW = 7'h50;
  localparam logic [6:0] EEPROM_ADDR_HIGH = 7'h51;

  // Host/agent codes
  localparam logic [2:0] HA_AGENT_ALL = 3'h0;
  localparam logic [2:0] HA_EP_LINK1 = 3'h1;
  localparam logic [2:0] HA_EP_LINK2 = 3'h2;
  localparam logic [2:0] HA_EP_LINK3 = 3'h3;
  localparam logic [2:0] HA_EP_LINK12 = 3'h4;
  localparam logic [2:0] HA_EP_LINK13 = 3'h5;
  localparam logic [2:0] HA_EP_LINK23 = 3'h6;
  localparam logic [2:0] HA_ROOT = 3'h7;

endpackage

`default_nettype wire

// *** core/rcs_strap_select.sv ***
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Ethernet four field 0: serial mode, lane 3
// - Field 1: parallel pins, or off if fast
// - Debug-to-ECC: debug on ECC, disconnect memories
// - Debug bit 1: ECC pins behave normally
// - Memory debug selector routes source; 01 reserved
// - Host code 000: agent on every interface
// - Codes 001-011: endpoint on one link
// - Codes 100, 110: endpoint on two links
// - Code 101: endpoint on links 1 and 3
// - Code 111: host and root complex everywhere
module rcs_strap_select (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Board inputs, asynchronous
  input wire logic [4:0] switch_bank_four,
  input wire logic [2:0] switch_bank_five,
  input wire logic config_drive_window,
  input wire logic fast_eth_ctrl_enable,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Strap pins toward the processor
  output logic serial_out_strap_pin_o,
  output logic serial_out_strap_pin_oe,
  output logic debug_ecc_strap_pin_o,
  output logic debug_ecc_strap_pin_oe,
  output logic mem_debug_strap_pin_a_o,
  output logic mem_debug_strap_pin_a_oe,
  output logic mem_debug_strap_pin_b_o,
  output logic mem_debug_strap_pin_b_oe,
  output logic [2:0] host_agent_strap_pins_o,
  output logic [2:0] host_agent_strap_pins_oe,
  // Static select
  output logic eeprom_addr_select,
  output logic [6:0] eeprom_bus_addr,
  // Decoded configuration, latched at window close except the live code error and fast choice
  output logic eth4_serial_mode,
  output logic [1:0] eth4_serial_lane,
  output logic eth4_parallel_pins,
  output logic eth4_powered_down,
  output logic ecc_debug_drive,
  output logic ecc_disconnect_memory,
  output logic [2:0] mem_debug_route,
  output logic mem_debug_code_error,
  output logic agent_all_interfaces,
  output logic [3:1] link_endpoint,
  output logic root_complex
);

  logic [7:0] ovr_enable_q;
  logic [7:0] ovr_value_q;
  logic [7:0] sw_meta_q;
  logic [7:0] sw_sync_q;
  logic [1:0] ctl_meta_q;
  logic [1:0] ctl_sync_q;
  logic window_level;
  logic fast_level;
  logic win_prev_q;
  logic [7:0] applied_d;
  logic [7:0] latched_q;
  logic [1:0] memdbg_drive;
  logic window_close;
  logic [7:0] mode_word;
  logic [1:0] memdbg_latched;
  logic [2:0] hostagt_latched;
  logic memdbg_reserved;

  // Switch word synchroniser, both stages reset to the default word
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_meta_q <= rcs_pkg::RST_OVR_VALUE;
      sw_sync_q <= rcs_pkg::RST_OVR_VALUE;
    end else begin
      sw_meta_q <= {switch_bank_five, switch_bank_four};
      sw_sync_q <= sw_meta_q;
    end
  end

  // Two-stage synchroniser for the window and the fast enable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_meta_q <= 2'h0;
      ctl_sync_q <= 2'h0;
    end else begin
      ctl_meta_q <= {fast_eth_ctrl_enable, config_drive_window};
      ctl_sync_q <= ctl_meta_q;
    end
  end

  // Synchronised control levels
  assign window_level = ctl_sync_q[0];
  assign fast_level = ctl_sync_q[1];

  // Window edge tracking on the synchronised level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_prev_q <= 1'b0;
    end else begin
      win_prev_q <= window_level;
    end
  end

  assign window_close = win_prev_q && !window_level;

  // Per-bit source choice: register value where enabled, else switch
  for (genvar b = 0; b < 8; b++) begin : g_src
    assign applied_d[b] = ovr_enable_q[b] ? ovr_value_q[b] :
                          sw_sync_q[b];
  end

  // Chosen memory debug code is the reserved one
  assign memdbg_reserved =
    applied_d[rcs_pkg::FLD_MEMDBG_HI:rcs_pkg::FLD_MEMDBG_LO] ==
    rcs_pkg::MEMDBG_RESERVED;

  // Reserved memory debug code is replaced by the default on the pins
  always_comb begin
    memdbg_drive = applied_d[rcs_pkg::FLD_MEMDBG_HI:rcs_pkg::FLD_MEMDBG_LO];
    if (memdbg_reserved) begin
      memdbg_drive = rcs_pkg::MEMDBG_MEM_CTRL2;
    end
  end

  // Override enable register, one bit per word bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_enable_q <= rcs_pkg::RST_OVR_ENABLE;
    end else if (reg_write && reg_addr == rcs_pkg::REG_OVR_ENABLE) begin
      ovr_enable_q <= reg_wdata;
    end
  end

  // Override value register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_value_q <= rcs_pkg::RST_OVR_VALUE;
    end else if (reg_write && reg_addr == rcs_pkg::REG_OVR_VALUE) begin
      ovr_value_q <= reg_wdata;
    end
  end

  // Mode word: decoded role and status bits
  always_comb begin
    mode_word = {mem_debug_code_error, eth4_powered_down, ecc_debug_drive,
                 root_complex, link_endpoint, agent_all_interfaces};
  end

  // Read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        rcs_pkg::REG_OVR_ENABLE: reg_rdata <= ovr_enable_q;
        rcs_pkg::REG_OVR_VALUE: reg_rdata <= ovr_value_q;
        rcs_pkg::REG_SWITCH: reg_rdata <= sw_sync_q;
        rcs_pkg::REG_APPLIED: reg_rdata <= latched_q;
        rcs_pkg::REG_MODE: reg_rdata <= mode_word;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Strap values follow the applied word every cycle, memory debug pins after the reserved code is replaced
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_strap_pin_o <= 1'b0;
      debug_ecc_strap_pin_o <= 1'b0;
      mem_debug_strap_pin_a_o <= 1'b0;
      mem_debug_strap_pin_b_o <= 1'b0;
      host_agent_strap_pins_o <= 3'h0;
    end else begin
      serial_out_strap_pin_o <= applied_d[rcs_pkg::FLD_ETH4];
      debug_ecc_strap_pin_o <= applied_d[rcs_pkg::FLD_DBG_ECC];
      mem_debug_strap_pin_a_o <= memdbg_drive[1]; // High code bit
      mem_debug_strap_pin_b_o <= memdbg_drive[0]; // Low code bit
      host_agent_strap_pins_o <=
        applied_d[rcs_pkg::FLD_HOSTAGT_HI:rcs_pkg::FLD_HOSTAGT_LO];
    end
  end

  // Strap pins driven only while the window is open
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_strap_pin_oe <= 1'b0;
      debug_ecc_strap_pin_oe <= 1'b0;
      mem_debug_strap_pin_a_oe <= 1'b0;
      mem_debug_strap_pin_b_oe <= 1'b0;
      host_agent_strap_pins_oe <= 3'h0;
    end else begin
      serial_out_strap_pin_oe <= window_level;
      debug_ecc_strap_pin_oe <= window_level;
      mem_debug_strap_pin_a_oe <= window_level;
      mem_debug_strap_pin_b_oe <= window_level;
      host_agent_strap_pins_oe <= {3{window_level}};
    end
  end

  // Static EEPROM select, follows its source at all times
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_addr_select <= 1'b0;
    end else begin
      eeprom_addr_select <= applied_d[rcs_pkg::FLD_EEPROM];
    end
  end

  // Bus address that the select stands for
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_bus_addr <= rcs_pkg::EEPROM_ADDR_LOW;
    end else if (applied_d[rcs_pkg::FLD_EEPROM]) begin
      eeprom_bus_addr <= rcs_pkg::EEPROM_ADDR_HIGH;
    end else begin
      eeprom_bus_addr <= rcs_pkg::EEPROM_ADDR_LOW;
    end
  end

  // Value the processor sampled, caught as the window closes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latched_q <= rcs_pkg::RST_OVR_VALUE;
    end else if (window_close) begin
      latched_q <= {
        applied_d[rcs_pkg::FLD_HOSTAGT_HI:rcs_pkg::FLD_HOSTAGT_LO],
        memdbg_drive,
        applied_d[rcs_pkg::FLD_EEPROM:rcs_pkg::FLD_ETH4]};
    end
  end

  // Latched field slices feeding the decoders
  assign memdbg_latched =
    latched_q[rcs_pkg::FLD_MEMDBG_HI:rcs_pkg::FLD_MEMDBG_LO];
  assign hostagt_latched =
    latched_q[rcs_pkg::FLD_HOSTAGT_HI:rcs_pkg::FLD_HOSTAGT_LO];

  // Ethernet four serial mode and its lane
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eth4_serial_mode <= 1'b0;
      eth4_serial_lane <= 2'h0;
    end else if (latched_q[rcs_pkg::FLD_ETH4] == rcs_pkg::ETH4_SERIAL) begin
      eth4_serial_mode <= 1'b1;
      eth4_serial_lane <= rcs_pkg::ETH4_SERIAL_LANE;
    end else begin
      eth4_serial_mode <= 1'b0;
      eth4_serial_lane <= 2'h0;
    end
  end

  // Ethernet four parallel pins, or powered down beside fast Ethernet
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eth4_parallel_pins <= 1'b0;
      eth4_powered_down <= 1'b0;
    end else if (latched_q[rcs_pkg::FLD_ETH4] == rcs_pkg::ETH4_SERIAL) begin
      eth4_parallel_pins <= 1'b0;
      eth4_powered_down <= 1'b0;
    end else begin
      eth4_parallel_pins <= !fast_level;
      eth4_powered_down <= fast_level;
    end
  end

  // Debug on ECC pins when the latched bit selects it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ecc_debug_drive <= 1'b0;
    end else begin
      ecc_debug_drive <=
        latched_q[rcs_pkg::FLD_DBG_ECC] == rcs_pkg::DBG_ECC_ON;
    end
  end

  // Board cuts the ECC lines from memory while debug drives them
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ecc_disconnect_memory <= 1'b0;
    end else begin
      ecc_disconnect_memory <=
        latched_q[rcs_pkg::FLD_DBG_ECC] == rcs_pkg::DBG_ECC_ON;
    end
  end

  // Memory debug source route: one-hot local bus, ctrl 1, ctrl 2
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_debug_route <= 3'h0;
    end else begin
      unique case (memdbg_latched)
        rcs_pkg::MEMDBG_LOCAL_BUS: mem_debug_route <= 3'h1;
        rcs_pkg::MEMDBG_MEM_CTRL1: mem_debug_route <= 3'h2;
        rcs_pkg::MEMDBG_MEM_CTRL2: mem_debug_route <= 3'h4;
        rcs_pkg::MEMDBG_RESERVED: mem_debug_route <= 3'h0;
      endcase
    end
  end

  // Flags a reserved code chosen at the source, live level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_debug_code_error <= 1'b0;
    end else begin
      mem_debug_code_error <= memdbg_reserved;
    end
  end

  // Host/agent role decode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      agent_all_interfaces <= 1'b0;
      link_endpoint <= 3'h0;
      root_complex <= 1'b0;
    end else begin
      agent_all_interfaces <= 1'b0;
      root_complex <= 1'b0;
      unique case (hostagt_latched)
        rcs_pkg::HA_AGENT_ALL: begin
          agent_all_interfaces <= 1'b1;
          link_endpoint <= 3'h0;
        end
        rcs_pkg::HA_EP_LINK1: link_endpoint <= 3'h1;
        rcs_pkg::HA_EP_LINK2: link_endpoint <= 3'h2;
        rcs_pkg::HA_EP_LINK3: link_endpoint <= 3'h4;
        rcs_pkg::HA_EP_LINK12: link_endpoint <= 3'h3;
        rcs_pkg::HA_EP_LINK23: link_endpoint <= 3'h6;
        rcs_pkg::HA_EP_LINK13: link_endpoint <= 3'h5;
        rcs_pkg::HA_ROOT: begin
          root_complex <= 1'b1;
          link_endpoint <= 3'h0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** bench/rcs_strap_select_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcs_strap_select_chk (
  // Watched ports
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic config_drive_window,
  input wire logic serial_out_strap_pin_oe,
  input wire logic debug_ecc_strap_pin_oe,
  input wire logic mem_debug_strap_pin_a_o,
  input wire logic mem_debug_strap_pin_b_o,
  input wire logic mem_debug_strap_pin_a_oe,
  input wire logic mem_debug_strap_pin_b_oe,
  input wire logic [2:0] host_agent_strap_pins_oe,
  input wire logic eeprom_addr_select,
  input wire logic [6:0] eeprom_bus_addr,
  input wire logic eth4_serial_mode,
  input wire logic [1:0] eth4_serial_lane,
  input wire logic eth4_parallel_pins,
  input wire logic [2:0] mem_debug_route,
  input wire logic agent_all_interfaces,
  input wire logic [3:1] link_endpoint,
  input wire logic root_complex
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Window seen high on three edges
  sequence win_held_s;
    config_drive_window [*3];
  endsequence
  // Strap drive, decode and static select
  chk_oe_lag: assert property (serial_out_strap_pin_oe ==
    $past(config_drive_window, 3)) else $error("enable lag wrong");
  chk_oe_rise: assert property (win_held_s |=>
    serial_out_strap_pin_oe) else $error("enable not raised");
  chk_oe_same: assert property ({debug_ecc_strap_pin_oe,
    mem_debug_strap_pin_a_oe, mem_debug_strap_pin_b_oe,
    host_agent_strap_pins_oe} == {6{serial_out_strap_pin_oe}})
    else $error("enables differ");
  chk_memdbg_code: assert property (mem_debug_strap_pin_b_oe |->
    mem_debug_strap_pin_a_o || !mem_debug_strap_pin_b_o)
    else $error("code 01 driven");
  chk_eeprom_addr: assert property (eeprom_bus_addr ==
    (eeprom_addr_select ? 7'h51 : 7'h50)) else $error("eeprom address");
  chk_eth4_lane: assert property (eth4_serial_mode |->
    eth4_serial_lane == 2'h3 && !eth4_parallel_pins) else $error("lane");
  chk_route_hot: assert property ($onehot0(mem_debug_route))
    else $error("route not one-hot");
  chk_root_only: assert property (root_complex |->
    !agent_all_interfaces && link_endpoint == 3'h0) else $error("root");
endmodule
bind rcs_strap_select rcs_strap_select_chk i_rcs_strap_select_chk (.*);
`default_nettype wire

// *** bench/rcs_proc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcs_proc_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Strap pins and enable
  input wire logic [7:0] pin_o,
  input wire logic pin_oe,
  // Word held after the window
  output logic [7:0] strap_word
);
  // Sample only while driven; debug bit 0 means debug on ECC
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_word <= 8'h00;
    end else if (pin_oe) begin
      strap_word <= pin_o;
    end
  end
endmodule
`default_nettype wire

// *** bench/rcs_strap_select_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcs_strap_select_test;
  // Stimulus, outputs, counters
  logic sys_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic config_drive_window = 1'b0, fast_eth_ctrl_enable = 1'b0;
  logic [4:0] switch_bank_four = 5'h1b;
  logic [2:0] switch_bank_five = 3'h7, host_agent_strap_pins_o;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, strap_word;
  logic serial_out_strap_pin_o, serial_out_strap_pin_oe;
  logic debug_ecc_strap_pin_o, debug_ecc_strap_pin_oe;
  logic mem_debug_strap_pin_a_o, mem_debug_strap_pin_a_oe;
  logic mem_debug_strap_pin_b_o, mem_debug_strap_pin_b_oe;
  logic [2:0] host_agent_strap_pins_oe, mem_debug_route;
  logic [3:1] link_endpoint;
  logic [6:0] eeprom_bus_addr;
  logic [1:0] eth4_serial_lane;
  logic eeprom_addr_select, eth4_serial_mode, eth4_parallel_pins;
  logic eth4_powered_down, ecc_debug_drive, ecc_disconnect_memory;
  logic mem_debug_code_error, agent_all_interfaces, root_complex;
  int bad_count = 0, comparisons = 0, cyc = 0;
  logic [2:0] ep_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6, 3'h0};
  // Device and processor model
  rcs_strap_select i_rcs_strap_select (.*);
  rcs_proc_model i_rcs_proc_model (.sys_clk, .reset_n, .strap_word,
    .pin_oe(serial_out_strap_pin_oe), .pin_o({host_agent_strap_pins_o,
    mem_debug_strap_pin_a_o, mem_debug_strap_pin_b_o, 1'b0,
    debug_ecc_strap_pin_o, serial_out_strap_pin_o}));
  // Clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  // Count a comparison, report a mismatch
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Wait edges, then settle on a falling edge
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // One register write or read; a read is compared
  task automatic reg_op(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= wr;
    reg_read <= !wr;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    tick(0);
    if (!wr) check("reg_rdata", reg_rdata, d);
  endtask
  // Open or close the drive window
  task automatic window(logic on, int n);
    @(posedge sys_clk);
    config_drive_window <= on;
    tick(n);
  endtask
  // Counts, verdict, stop
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Reset, switch sweep, register override
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(2);
    check("reset", {root_complex, eeprom_bus_addr}, 8'hd0);
    reg_op(1'b0, rcs_pkg::REG_OVR_VALUE, 8'hfb);
    reg_op(1'b0, rcs_pkg::REG_APPLIED, 8'hfb);
    reg_op(1'b0, 8'h20, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {switch_bank_five, switch_bank_four, fast_eth_ctrl_enable} <=
        {i[2:0], i[1], i[0], i[2], i[1], i[0], i[2]};
      window(1'b1, 5);
      check("pins", {host_agent_strap_pins_o,
        host_agent_strap_pins_oe, mem_debug_strap_pin_a_o,
        mem_debug_strap_pin_b_o}, {i[2:0], 3'h7, i[1] | i[0], i[0]});
      check("static", {eeprom_bus_addr,
        mem_debug_code_error}, {7'h50 + i[2], i[1:0] == 2'h1});
      window(1'b0, 6);
      check("model", strap_word,
        {i[2:0], i[1] | i[0], i[0], 1'b0, i[1:0]});
      check("off", {serial_out_strap_pin_oe,
        ecc_debug_drive, ecc_disconnect_memory}, {1'b0, {2{~i[1]}}});
      check("decode", {mem_debug_route, eth4_serial_mode,
        eth4_serial_lane, eth4_parallel_pins, eth4_powered_down},
        {((i[1] | i[0]) ? {i[0], ~i[0], 1'b0} : 3'h1), ~i[0],
        {2{~i[0]}}, i[0] & ~i[2], i[0] & i[2]});
      check("host", {agent_all_interfaces,
        link_endpoint, root_complex}, {i == 0, ep_tab[i], i == 7});
    end
    $display("test switches done");
    reg_op(1'b1, rcs_pkg::REG_OVR_VALUE, 8'h0a);
    reg_op(1'b1, rcs_pkg::REG_OVR_ENABLE, 8'hff);
    reg_op(1'b1, rcs_pkg::REG_SWITCH, 8'h00);
    reg_op(1'b0, rcs_pkg::REG_SWITCH, 8'hff);
    check("ovr static", {eeprom_addr_select,
      mem_debug_code_error}, 8'h01);
    window(1'b1, 5);
    check("ovr pins", {mem_debug_strap_pin_a_o,
      mem_debug_strap_pin_b_o, host_agent_strap_pins_o}, 8'h18);
    window(1'b0, 6);
    reg_op(1'b0, rcs_pkg::REG_APPLIED, 8'h1a);
    reg_op(1'b0, rcs_pkg::REG_MODE, 8'h81);
    $display("test override done");
    print_verdict();
  end
endmodule
`default_nettype wire
